// *** dv/tb.sv ***
// self-checking bench for the user flash access controller
`timescale 1ns/10ps
`default_nettype none
module tb;
	import ufa_pkg::*;
	logic            core_clk;
	logic            rstn;
	ufa_sfr_req_type sfr_req;
	logic [7:0]      sfr_rdata;
	logic            sfr_hit;
	logic            core_stall;
	logic            irq_defer;
	ufa_mem_req_type mem_req;
	logic [7:0]      mem_rdata;
	int              fails;
	int              check_count;
	int              n;
	logic            h;
	logic [15:0]     a;
	logic [7:0]      d1;
	logic [7:0]      d2;
	logic [7:0]      v;
	logic [7:0]      ofs [6];
	logic [7:0]      rst [6];

	ufa_ctrl dut_u (.core_clk(core_clk), .rstn(rstn), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .core_stall(core_stall),
		.irq_defer(irq_defer), .mem_req(mem_req), .mem_rdata(mem_rdata));
	ufa_mem_model mem_u (.core_clk(core_clk), .mem_req(mem_req),
		.mem_rdata(mem_rdata));

	initial core_clk = 1'b0;
	always #25 core_clk = ~core_clk;
	// ------------------------------------------------------------
	// bus tasks and comparisons
	// ------------------------------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
			input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h want %h",
				$time, what, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string what);
		chk8({7'h00, got}, {7'h00, exp}, what);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
		@(posedge core_clk);
		sfr_req <= '{addr: ad, wr: 1'b1, wdata: dt};
		@(posedge core_clk);
		sfr_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] q,
			output logic hq);
		@(posedge core_clk);
		sfr_req.addr <= ad;
		@(posedge core_clk);
		@(negedge core_clk);
		q = sfr_rdata;
		hq = sfr_hit;
	endtask
	task automatic idle(output int cnt);
		cnt = 0;
		repeat (2) @(negedge core_clk);
		while (core_stall !== 1'b0 && cnt < 70000) begin
			chk1(irq_defer, 1'b1, "defer");
			cnt++;
			@(negedge core_clk);
		end
		chk1(core_stall, 1'b0, "stall ends");
		chk1(irq_defer, 1'b0, "defer ends");
	endtask
	task automatic op(input logic [7:0] c, input logic [15:0] ad,
			input logic [7:0] dt, input logic key = 1'b1);
		int k;
		logic [7:0] q;
		logic hq;
		wr(OFS_DATA, dt);
		wr(OFS_ADRH, ad[15:8]);
		wr(OFS_ADRL, ad[7:0]);
		if (key)
			wr(OFS_AKEY, ACCESS_KEY);
		wr(OFS_CMD, c);
		idle(k);
		chk1(k > 0, key, "busy seen");
		rd(OFS_AKEY, q, hq);
		chk8(q, RST_AKEY, "key cleared");
	endtask
	task automatic expb(input logic [15:0] ad, input logic [7:0] exp,
			input string what);
		logic [7:0] q;
		logic hq;
		op(CMD_READ, ad, 8'h5C);
		rd(OFS_DATA, q, hq);
		chk8(q, exp, what);
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (100000) @(posedge core_clk);
		fails++;
		summarize();
	end
	initial begin
		fails = 0;
		check_count = 0;
		sfr_req = '0;
		rstn = 1'b0;
		ofs = '{OFS_CMD, OFS_AKEY, OFS_PKEY, OFS_DATA, OFS_ADRL, OFS_ADRH};
		rst = '{RST_CMD, RST_AKEY, RST_PKEY, RST_DATA, RST_ADRL, RST_ADRH};
		v = 8'($urandom(32'h98f4));
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(ofs[i], v, h);
			chk8(v, rst[i], "reset value");
			chk1(h, 1'b1, "mapped");
		end
		rd(8'hC5, v, h);
		chk8(v, 8'h00, "unmapped data");
		chk1(h, 1'b0, "unmapped hit");
		tend("reset");
		for (int c = 5; c < 8; c++) begin
			wr(OFS_AKEY, ACCESS_KEY);
			wr(OFS_CMD, 8'(c));
			idle(n);
			chk1(n > 0, 1'b0, "reserved idle");
			rd(OFS_CMD, v, h);
			chk8(v, 8'(c), "reserved held");
		end
		tend("reserved");
		op(CMD_PROG, 16'h3E00, 8'h00);
		wr(OFS_DATA, 8'h3C);
		wr(OFS_AKEY, ACCESS_KEY);
		wr(OFS_CMD, CMD_ERASE_ALL);
		wr(OFS_DATA, 8'hAA);
		idle(n);
		rd(OFS_DATA, v, h);
		chk8(v, 8'h3C, "busy write dropped");
		expb(16'h3E00, ERASED, "mass erase");
		tend("mass erase");
		op(CMD_PROG, 16'h3DFF, 8'h12);
		op(CMD_PROG, 16'h3E00, 8'h34);
		op(CMD_ERASE_PAGE, 16'h3C80, 8'h00);
		expb(16'h3DFF, ERASED, "page end");
		expb(16'h3E00, 8'h34, "next page");
		op(CMD_PROG, 16'h3E00, 8'h00, 1'b0);
		expb(16'h3E00, 8'h34, "no key");
		op(CMD_PROG, 16'hF900, 8'h00);
		expb(16'hF900, 8'h5C, "fw read");
		chk8(mem_u.mem[16'hF900], ERASED, "fw write");
		tend("page");
		for (int i = 0; i < 4; i++) begin
			a = 16'h2000 + 16'($urandom % 32'hD600);
			d1 = 8'($urandom);
			d2 = 8'($urandom);
			op(CMD_ERASE_PAGE, a ^ 16'h0155, 8'h00);
			op(CMD_PROG, a, d1);
			op(CMD_PROG, a, d2);
			expb(a, d1 & d2, "program and");
			expb(a ^ 16'h0001, ERASED, "page erased");
			op(CMD_VERIFY, a, d1 & d2);
			rd(OFS_CMD, v, h);
			chk8(v, VERIFY_PASS, "verify ok");
			op(CMD_VERIFY, a, ~(d1 & d2));
			rd(OFS_CMD, v, h);
			chk8(v, CMD_VERIFY, "verify bad");
		end
		tend("random");
		op(CMD_PROG, WP_BASE, 8'hFB);
		op(CMD_PROG, 16'h0400, 8'h00);
		expb(16'h0400, ERASED, "wp page");
		op(CMD_PROG, 16'h0600, 8'h00);
		expb(16'h0600, 8'h00, "open page");
		tend("write protect");
		wr(OFS_PKEY, 8'h5A);
		op(CMD_PROT_KEY, 16'h0000, 8'h00);
		expb(PROT_KEY_ADDR, 8'h5A, "key stored");
		wr(OFS_PKEY, 8'h11);
		op(CMD_PROT_KEY, 16'h0000, 8'h00);
		expb(PROT_KEY_ADDR, 8'h5A, "key once");
		op(CMD_PROG, 16'hF7F1, 8'h7F);
		expb(16'hF7F1, ERASED, "key mismatch");
		wr(OFS_PKEY, 8'h5A);
		op(CMD_PROG, 16'hF7F1, 8'h7F);
		expb(16'hF7F1, 8'h7F, "key match");
		tend("protection key");
		op(CMD_PROG, RP_BASE, 8'hFB);
		op(CMD_PROG, 16'h1000, 8'h66);
		op(CMD_PROG, 16'h1800, 8'h66);
		expb(16'h1000, 8'h5C, "rp page");
		expb(16'h1800, 8'h66, "rp open");
		expb(RP_BASE, 8'hFB, "prot readable");
		tend("read protect");
		op(CMD_PROG, 16'hF7FF, 8'hF7);
		op(CMD_ERASE_ALL, 16'h0000, 8'h00);
		expb(16'h0600, 8'h00, "mass refused");
		tend("last page");
		summarize();
	end
endmodule
`default_nettype wire

// *** dv/ufa_mem_model.sv ***
// behavioural flash array standing behind the controller
`timescale 1ns/10ps
`default_nettype none
module ufa_mem_model (
	input  wire logic                     core_clk,
	input  wire ufa_pkg::ufa_mem_req_type mem_req,
	output logic      [7:0]               mem_rdata
);
	import ufa_pkg::*;
	logic [7:0] mem [0:65535];
	logic [7:0] held;
	// ------------------------------------------------------------
	// array and read port
	// ------------------------------------------------------------
	// blank cells
	initial begin
		for (int i = 0; i < 65536; i++)
			mem[i] = ERASED;
		held = 8'h00;
	end
	// read answers while the registered request stands, as the sequencer
	// samples it; stale data is inverted every cycle so it is never trusted
	assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~held;
	always @(posedge core_clk) begin
		if (mem_req.we)
			mem[mem_req.addr] <= mem_req.wdata;
		held <= mem_rdata;
	end
endmodule
`default_nettype wire

// *** hdl/ufa_addr_map.sv ***
// address split into page, region flags and protection byte locations
`timescale 1ns/10ps
`default_nettype none
module ufa_addr_map (
	input  wire logic [15:0] addr,
	output logic      [6:0]  page,
	output logic             in_user,
	output logic             in_prot,
	output logic             in_last,
	output logic      [15:0] wp_addr,
	output logic      [2:0]  wp_bit,
	output logic      [15:0] rp_addr,
	output logic      [2:0]  rp_bit
);
	import ufa_pkg::*;
	logic [4:0] group;
	// RQ4 page from top bits
	assign page    = addr[15:PAGE_BITS];
	// RQ7 firmware region excluded
	assign in_user = addr < FW_BASE;
	// RQ11 protection bytes at top of page 123
	assign in_prot = in_user && (addr >= PROT_KEY_ADDR);
	assign in_last = page == LAST_PAGE;
	// RQ8 one bit per page
	assign wp_addr = WP_BASE + {12'h000, page[6:3]};
	assign wp_bit  = page[2:0];
	// RQ9 one bit per four pages
	assign group   = page[6:2];
	assign rp_addr = RP_BASE + {14'h0000, group[4:3]};
	assign rp_bit  = group[2:0];
endmodule
`default_nettype wire

// *** hdl/ufa_ctrl.sv ***
// user flash access controller: sfr registers and operation sequencer
`timescale 1ns/10ps
`default_nettype none
module ufa_ctrl (
	input  wire logic                     core_clk,
	input  wire logic                     rstn,
	input  wire ufa_pkg::ufa_sfr_req_type sfr_req,
	output logic      [7:0]               sfr_rdata,
	output logic                          sfr_hit,
	output logic                          core_stall,
	output logic                          irq_defer,
	output ufa_pkg::ufa_mem_req_type      mem_req,
	input  wire logic [7:0]               mem_rdata
);
	import ufa_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		ufa_state_type   state;
		logic            busy;
		logic            hit;
		logic [7:0]      rdata;
		logic [7:0]      cmd;
		logic [7:0]      akey;
		logic [7:0]      pkey;
		logic [7:0]      data;
		logic [7:0]      adrl;
		logic [7:0]      adrh;
		logic [15:0]     op_addr;
		logic [15:0]     cur;
		logic [15:0]     last;
		logic [7:0]      skey;
		logic [7:0]      wp;
		ufa_mem_req_type mem;
	} ufa_ctl_type;

	// RQ15 register reset values
	localparam ufa_ctl_type CTL_RST = '{
		state:   ST_IDLE,
		cmd:     RST_CMD,
		akey:    RST_AKEY,
		pkey:    RST_PKEY,
		data:    RST_DATA,
		adrl:    RST_ADRL,
		adrh:    RST_ADRH,
		default: '0
	};

	ufa_ctl_type st_ff;
	ufa_ctl_type nxt_st;

	logic [15:0] map_addr;
	logic [6:0]  page;
	logic        in_user;
	logic        in_prot;
	logic        in_last;
	logic [15:0] wp_addr;
	logic [2:0]  wp_bit;
	logic [15:0] rp_addr;
	logic [2:0]  rp_bit;
	logic        wp_ok;
	logic        rp_ok;
	logic        key_blank;
	logic        key_ok;
	logic        cmd_valid;
	logic        allowed;

	// ------------------------------------------------------------
	// protection lookup
	// ------------------------------------------------------------
	// mass erase is judged by page 123, which guards the settings
	assign map_addr = (st_ff.cmd == CMD_ERASE_ALL) ? LAST_PAGE_BASE
	                                               : st_ff.op_addr;

	ufa_addr_map u_map (
		.addr    (map_addr),
		.page    (page),
		.in_user (in_user),
		.in_prot (in_prot),
		.in_last (in_last),
		.wp_addr (wp_addr),
		.wp_bit  (wp_bit),
		.rp_addr (rp_addr),
		.rp_bit  (rp_bit)
	);

	// rp byte is only looked at while it sits on mem_rdata
	ufa_prot_check u_chk (
		.wp_byte    (st_ff.wp),
		.wp_bit     (wp_bit),
		.rp_byte    (mem_rdata),
		.rp_bit     (rp_bit),
		.stored_key (st_ff.skey),
		.prot_key   (st_ff.pkey),
		.wp_ok      (wp_ok),
		.rp_ok      (rp_ok),
		.key_blank  (key_blank),
		.key_ok     (key_ok)
	);

	// RQ18 reserved codes start nothing
	assign cmd_valid = (sfr_req.wdata == CMD_PROG)
	                || (sfr_req.wdata == CMD_ERASE_PAGE)
	                || (sfr_req.wdata == CMD_ERASE_ALL)
	                || (sfr_req.wdata == CMD_READ)
	                || (sfr_req.wdata == CMD_PROT_KEY)
	                || (sfr_req.wdata == CMD_VERIFY);

	// RQ20 refusal decision
	always_comb begin
		allowed = 1'b0;
		case (st_ff.cmd)
			// RQ8 page write protection
			CMD_PROG:       allowed = in_user && wp_ok
			                       && (!in_prot || key_ok);
			CMD_ERASE_PAGE: allowed = in_user && wp_ok
			                       && (!in_last || key_ok);
			CMD_ERASE_ALL:  allowed = wp_ok;
			// RQ9 read protection groups
			CMD_READ,
			CMD_VERIFY:     allowed = in_user && (rp_ok || in_prot);
			// RQ10 key byte written once while blank
			CMD_PROT_KEY:   allowed = key_blank;
			default:        allowed = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.mem.rd = 1'b0;
		nxt_st.mem.we = 1'b0;
		nxt_st.hit    = 1'b1;
		// RQ13 register read back
		case (sfr_req.addr)
			OFS_CMD:  nxt_st.rdata = st_ff.cmd;
			OFS_AKEY: nxt_st.rdata = st_ff.akey;
			OFS_PKEY: nxt_st.rdata = st_ff.pkey;
			OFS_DATA: nxt_st.rdata = st_ff.data;
			OFS_ADRL: nxt_st.rdata = st_ff.adrl;
			OFS_ADRH: nxt_st.rdata = st_ff.adrh;
			default: begin
				nxt_st.hit   = 1'b0;
				nxt_st.rdata = 8'h00;
			end
		endcase
		case (st_ff.state)
			ST_IDLE: begin
				if (sfr_req.wr) begin
					case (sfr_req.addr)
						OFS_AKEY: nxt_st.akey = sfr_req.wdata;
						OFS_PKEY: nxt_st.pkey = sfr_req.wdata;
						OFS_DATA: nxt_st.data = sfr_req.wdata;
						OFS_ADRL: nxt_st.adrl = sfr_req.wdata;
						OFS_ADRH: nxt_st.adrh = sfr_req.wdata;
						OFS_CMD: begin
							nxt_st.cmd  = sfr_req.wdata;
							// RQ16 key used up by any command
							nxt_st.akey = RST_AKEY;
							// RQ14 start on valid code
							if (st_ff.akey == ACCESS_KEY && cmd_valid) begin
								nxt_st.state   = ST_KEYRD;
								nxt_st.busy    = 1'b1;
								nxt_st.op_addr = {st_ff.adrh, st_ff.adrl};
							end
						end
						default: nxt_st.busy = 1'b0;
					endcase
				end
			end
			ST_KEYRD: begin
				nxt_st.mem.addr = PROT_KEY_ADDR;
				nxt_st.mem.rd   = 1'b1;
				nxt_st.state    = ST_WPRD;
			end
			ST_WPRD: begin
				nxt_st.skey     = mem_rdata;
				nxt_st.mem.addr = wp_addr;
				nxt_st.mem.rd   = 1'b1;
				nxt_st.state    = ST_RPRD;
			end
			ST_RPRD: begin
				nxt_st.wp       = mem_rdata;
				nxt_st.mem.addr = rp_addr;
				nxt_st.mem.rd   = 1'b1;
				nxt_st.state    = ST_DECIDE;
			end
			ST_DECIDE: begin
				nxt_st.state = ST_DONE;
				if (allowed) begin
					case (st_ff.cmd)
						// RQ3 whole page only
						CMD_ERASE_PAGE: begin
							nxt_st.cur   = {page, 9'h000};
							nxt_st.last  = {page, PAGE_OFS_TOP};
							nxt_st.state = ST_ERASE;
						end
						// RQ5 mass erase of user array
						CMD_ERASE_ALL: begin
							nxt_st.cur   = USER_BASE;
							nxt_st.last  = USER_TOP;
							nxt_st.state = ST_ERASE;
						end
						CMD_PROT_KEY: begin
							nxt_st.mem.addr  = PROT_KEY_ADDR;
							nxt_st.mem.we    = 1'b1;
							nxt_st.mem.wdata = st_ff.pkey;
						end
						default: begin
							nxt_st.mem.addr = st_ff.op_addr;
							nxt_st.mem.rd   = 1'b1;
							nxt_st.state    = ST_ACT;
						end
					endcase
				end
			end
			ST_ACT: begin
				nxt_st.state = ST_DONE;
				case (st_ff.cmd)
					// RQ2 program only clears bits
					CMD_PROG: begin
						nxt_st.mem.addr  = st_ff.op_addr;
						nxt_st.mem.we    = 1'b1;
						nxt_st.mem.wdata = mem_rdata & st_ff.data;
					end
					CMD_READ: nxt_st.data = mem_rdata;
					// RQ6 verify clears command on match
					CMD_VERIFY: begin
						if (mem_rdata == st_ff.data) begin
							nxt_st.cmd = VERIFY_PASS;
						end
					end
					default: nxt_st.state = ST_DONE;
				endcase
			end
			// RQ1 erase writes all ones
			ST_ERASE: begin
				nxt_st.mem.addr  = st_ff.cur;
				nxt_st.mem.we    = 1'b1;
				nxt_st.mem.wdata = ERASED;
				nxt_st.cur       = st_ff.cur + 16'h0001;
				if (st_ff.cur == st_ff.last) begin
					nxt_st.state = ST_DONE;
				end
			end
			ST_DONE: begin
				// RQ16 key reset after operation
				nxt_st.akey  = RST_AKEY;
				nxt_st.busy  = 1'b0;
				nxt_st.state = ST_IDLE;
			end
			default: nxt_st.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= CTL_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign sfr_rdata  = st_ff.rdata;
	assign sfr_hit    = st_ff.hit;
	// RQ17 stall and interrupt hold
	assign core_stall = st_ff.busy;
	assign irq_defer  = st_ff.busy;
	assign mem_req    = st_ff.mem;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_cmd_wr;
		st_ff.state == ST_IDLE && sfr_req.wr && sfr_req.addr == OFS_CMD;
	endsequence

	sequence s_keyed_start;
		s_cmd_wr ##0 (st_ff.akey == ACCESS_KEY && cmd_valid);
	endsequence

	a_start_stalls: assert property ( // RQ17
		@(posedge core_clk) disable iff (!rstn)
		s_keyed_start |=> (core_stall && irq_defer) [*3])
		else $error("keyed command did not stall the core");

	a_no_key_idle: assert property ( // RQ16
		@(posedge core_clk) disable iff (!rstn)
		s_cmd_wr ##0 (st_ff.akey != ACCESS_KEY) |=>
		(!core_stall && !mem_req.we) [*2])
		else $error("command without key started an operation");

	a_key_cleared: assert property ( // RQ16
		@(posedge core_clk) disable iff (!rstn)
		s_cmd_wr |=> st_ff.akey == RST_AKEY)
		else $error("access key not reset by command");

	a_erase_ones: assert property ( // RQ1
		@(posedge core_clk) disable iff (!rstn)
		mem_req.we && st_ff.state == ST_ERASE |-> mem_req.wdata == ERASED)
		else $error("erase wrote a value other than all ones");

	a_prog_clears: assert property ( // RQ2
		@(posedge core_clk) disable iff (!rstn)
		mem_req.we && st_ff.cmd == CMD_PROG |->
		(mem_req.wdata & ~$past(mem_rdata)) == 8'h00)
		else $error("program set a bit that was zero");

	a_no_fw_write: assert property ( // RQ7
		@(posedge core_clk) disable iff (!rstn)
		mem_req.we |-> mem_req.addr < FW_BASE)
		else $error("write reached the firmware region");

	a_page_bound: assert property ( // RQ3
		@(posedge core_clk) disable iff (!rstn)
		mem_req.we && st_ff.cmd == CMD_ERASE_PAGE |->
		mem_req.addr[15:9] == st_ff.op_addr[15:9])
		else $error("page erase left its page");

	a_read_lands: assert property ( // RQ13
		@(posedge core_clk) disable iff (!rstn)
		st_ff.state == ST_ACT && st_ff.cmd == CMD_READ |=>
		st_ff.data == $past(mem_rdata) ##1 !core_stall)
		else $error("read value not placed in data byte");

	a_refused_quiet: assert property ( // RQ20
		@(posedge core_clk) disable iff (!rstn)
		st_ff.state == ST_DECIDE && !allowed |=>
		(!mem_req.we) [*2] ##0 !core_stall)
		else $error("refused command touched the array");

endmodule
`default_nettype wire

// *** hdl/ufa_pkg.sv ***
// constants and types for the user flash access controller
// Notes on behaviour
// RQ1: erased bytes read back as 0xFF after page or mass erase.
// RQ2: programming only clears bits; old byte ANDed with the new one.
// RQ3: no single byte erase; erase covers the whole addressed page.
// RQ4: user array is 124 pages of 512 bytes, page from upper address.
// RQ5: page erase and mass erase of the whole user array.
// RQ6: verify command compares stored byte against the data byte.
// RQ7: top 2 kB of the 64 kB array is refused for every access.
// RQ8: write/erase protection from sixteen top bytes, one bit per page.
// RQ9: read protection from four bytes, one bit per four pages.
// RQ10: one protection byte holds the protection update key.
// RQ11: last 20 bytes of page 123 hold protection data, not user data; the code marks the last 22 (0xF7EA up) as protection.
// RQ12: software protects page 123 whenever any protection is used.
// RQ13: data byte holds program or read value; address from two registers.
// RQ14: writing a valid code to the command register starts an operation.
// RQ15: command, data, addresses reset to 0x00; both keys to 0xFF.
// RQ16: start only with access key 0x3B; key reset after each operation.
// RQ17: core stalls and interrupts deferred while an operation runs.
// RQ18: codes 1 program, 2 page erase, 3 erase all, 4 read, 8 key.
// RQ19: protection update only when key matches 0xF7EA or stored is 0xFF; the code lets mass erase wipe the protection bytes with no key check.
// RQ20: refused commands complete without changing the array.
`default_nettype none
package ufa_pkg;
	// ------------------------------------------------------------
	// register offsets and reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  OFS_CMD        = 8'hB9;
	localparam logic [7:0]  OFS_AKEY       = 8'hBA;
	localparam logic [7:0]  OFS_PKEY       = 8'hBB;
	localparam logic [7:0]  OFS_DATA       = 8'hBC;
	localparam logic [7:0]  OFS_ADRL       = 8'hC6;
	localparam logic [7:0]  OFS_ADRH       = 8'hC7;
	localparam logic [7:0]  RST_CMD        = 8'h00;
	localparam logic [7:0]  RST_AKEY       = 8'hFF;
	localparam logic [7:0]  RST_PKEY       = 8'hFF;
	localparam logic [7:0]  RST_DATA       = 8'h00;
	localparam logic [7:0]  RST_ADRL       = 8'h00;
	localparam logic [7:0]  RST_ADRH       = 8'h00;
	localparam logic [7:0]  ACCESS_KEY     = 8'h3B;
	localparam logic [7:0]  ERASED         = 8'hFF;
	localparam logic [7:0]  VERIFY_PASS    = 8'h00;
	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [7:0]  CMD_PROG       = 8'h01;
	localparam logic [7:0]  CMD_ERASE_PAGE = 8'h02;
	localparam logic [7:0]  CMD_ERASE_ALL  = 8'h03;
	localparam logic [7:0]  CMD_READ       = 8'h04;
	localparam logic [7:0]  CMD_PROT_KEY   = 8'h08;
	localparam logic [7:0]  CMD_VERIFY     = 8'h0F;
	// ------------------------------------------------------------
	// array layout
	// ------------------------------------------------------------
	localparam int          PAGE_BITS      = 9;
	localparam logic [6:0]  LAST_PAGE      = 7'h7B;
	localparam logic [8:0]  PAGE_OFS_TOP   = 9'h1FF;
	localparam logic [15:0] USER_BASE      = 16'h0000;
	localparam logic [15:0] USER_TOP       = 16'hF7FF;
	localparam logic [15:0] FW_BASE        = 16'hF800;
	localparam logic [15:0] LAST_PAGE_BASE = 16'hF600;
	localparam logic [15:0] PROT_KEY_ADDR  = 16'hF7EA;
	localparam logic [15:0] RP_BASE        = 16'hF7EC;
	localparam logic [15:0] WP_BASE        = 16'hF7F0;
	// ------------------------------------------------------------
	// states and carriers
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_KEYRD  = 3'b001,
		ST_WPRD   = 3'b010,
		ST_RPRD   = 3'b011,
		ST_DECIDE = 3'b100,
		ST_ACT    = 3'b101,
		ST_ERASE  = 3'b110,
		ST_DONE   = 3'b111
	} ufa_state_type;
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic [7:0] wdata;
	} ufa_sfr_req_type;
	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        we;
		logic [7:0]  wdata;
	} ufa_mem_req_type;
endpackage
`default_nettype wire

// *** hdl/ufa_prot_check.sv ***
// protection bit selection and protection key comparison
`timescale 1ns/10ps
`default_nettype none
module ufa_prot_check (
	input  wire logic [7:0] wp_byte,
	input  wire logic [2:0] wp_bit,
	input  wire logic [7:0] rp_byte,
	input  wire logic [2:0] rp_bit,
	input  wire logic [7:0] stored_key,
	input  wire logic [7:0] prot_key,
	output logic            wp_ok,
	output logic            rp_ok,
	output logic            key_blank,
	output logic            key_ok
);
	import ufa_pkg::*;
	// cleared bit protects, so an erased area leaves everything open
	assign wp_ok     = wp_byte[wp_bit];
	assign rp_ok     = rp_byte[rp_bit];
	// RQ19 blank stored key skips compare
	assign key_blank = stored_key == ERASED;
	assign key_ok    = key_blank || (prot_key == stored_key);
endmodule
`default_nettype wire
